//--- pkg/urxb_pkg.sv
// Package: constants and carriers for the serial receiver with two-entry buffer
package urxb_pkg;

  // Oversampling: samples per bit and vote positions (first low sample is 1)
  localparam logic [3:0] NORM_LAST   = 4'hF;  // 16 states per bit, counted 0..15
  localparam logic [3:0] DBL_LAST    = 4'h7;  // 8 states per bit, counted 0..7
  localparam logic [3:0] NORM_VOTE_A = 4'h8;
  localparam logic [3:0] NORM_VOTE_C = 4'hA;
  localparam logic [3:0] DBL_VOTE_A  = 4'h4;
  localparam logic [3:0] DBL_VOTE_C  = 4'h6;

  // Character size codes
  localparam logic [2:0] CSZ_NINE    = 3'h7;
  localparam logic [3:0] DATA_BITS_5 = 4'h5;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  // Buffer depth
  localparam logic [1:0] BUF_DEPTH   = 2'h2;

  // Reset values
  localparam logic [8:0] DATA_RST    = 9'h000;
  localparam logic [1:0] SYNC_RST    = 2'h3;

  // One received character with its status
  typedef struct packed {
    logic [8:0] data;      // Bit 8 is the ninth bit
    logic       frame_err;
    logic       overrun;
    logic       parity_err;
  } urxb_entry_s;

  // Frame configuration
  typedef struct packed {
    logic [2:0] char_size_sel;
    logic       parity_enable_bit;
    logic       parity_odd_sel;
    logic       double_speed_sel;
  } urxb_cfg_s;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } urxb_state_e;

endpackage : urxb_pkg

//--- hdl/urxb_receiver.sv
// Design: serial receiver with start validation, majority vote and two-entry buffer
//
// Function
// RQ1 - With nine-bit characters software reads ninth bit before low data bits.
// RQ2 - Ninth bit and error bits live in each buffer entry; reads advance.
// RQ3 - Receive-complete reads one when buffer holds an unread character.
// RQ4 - Clearing receiver enable flushes buffer, receive-complete goes zero.
// RQ5 - Interrupt request held while enable and receive-complete, gated globally.
// RQ6 - Interrupt routine must read data to clear receive-complete.
// RQ7 - Error flags read-only, never raise interrupts.
// RQ8 - Software reads status before data, since reading data advances buffer.
// RQ9 - Frame error reflects first stop bit only, whatever the stop count.
// RQ10 - Overrun when buffer full, shifter waiting, and new start detected.
// RQ11 - Overrun cleared when a frame moves into the buffer.
// RQ12 - Parity checked only when enabled; odd select chooses odd or even.
// RQ13 - Parity error only when checking enabled and check failed.
// RQ14 - Disabling receiver is immediate, abandons reception, releases pin.
// RQ15 - Software flushes by reading data until receive-complete clears.
// RQ16 - Sample at sixteen times baud, eight in double speed.
// RQ17 - Start validated on samples 8,9,10 or 4,5,6 after falling edge.
// RQ18 - Two or more high validation samples reject start as noise.
// RQ19 - Bit timing resynchronised to each accepted start bit.
// RQ20 - Sixteen or eight sample states per bit, numbered by state.
// RQ21 - Bit value is majority of three centre samples.
// RQ22 - Recovery runs through first stop bit; further stop bits ignored.
// RQ23 - Stop bit majority voted; zero sets frame error.
// RQ24 - Unused upper data bits read as zero for short characters.
// RQ25 - Setting receiver enable takes over serial input pin.
// RQ26 - Serial input passes two-stage synchroniser before use.
// RQ27 - Sampling advances on single-cycle external sample tick.
`timescale 1ns/100ps

module urxb_receiver (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // Serial line and oversample tick
  input  wire logic                serial_input_pin,
  input  wire logic                sample_tick,
  // Configuration
  input  wire logic                rx_enable_bit,
  input  wire logic                rx_complete_irq_en,
  input  wire logic                global_irq_en,
  input  wire urxb_pkg::urxb_cfg_s cfg,
  // Data location read: one-cycle strobe advances the buffer
  input  wire logic                data_read,
  // Status and data of the next readable character
  output logic [7:0]               rx_data,
  output logic                     rx_ninth_bit,
  output logic                     frame_err_flag,
  output logic                     overrun_flag,
  output logic                     parity_err_flag,
  output logic                     rx_complete,
  output logic                     rx_irq,
  output logic                     pin_override
);

  // Synchroniser: first stage feeds only the second
  logic [1:0] sync_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync_r <= urxb_pkg::SYNC_RST;
    end else begin
      sync_r <= {sync_r[0], serial_input_pin};  // [RQ26]
    end
  end
  logic line_s;
  assign line_s = sync_r[1];

  // Frame geometry from configuration
  logic [3:0] last_state;
  logic [3:0] vote_a;
  logic [3:0] vote_c;
  logic [3:0] data_bits;
  logic [3:0] frame_bits;
  assign last_state = cfg.double_speed_sel ? urxb_pkg::DBL_LAST : urxb_pkg::NORM_LAST;  // [RQ16]
  assign vote_a     = cfg.double_speed_sel ? urxb_pkg::DBL_VOTE_A : urxb_pkg::NORM_VOTE_A;
  assign vote_c     = cfg.double_speed_sel ? urxb_pkg::DBL_VOTE_C : urxb_pkg::NORM_VOTE_C;
  assign data_bits  = (cfg.char_size_sel == urxb_pkg::CSZ_NINE) ? urxb_pkg::DATA_BITS_9
                    : (cfg.char_size_sel[2] ? urxb_pkg::DATA_BITS_5
                    : urxb_pkg::DATA_BITS_5 + {2'h0, cfg.char_size_sel[1:0]});
  // Data, optional parity, then first stop bit only
  assign frame_bits = data_bits + {3'h0, cfg.parity_enable_bit} + 4'h1;  // [RQ22]

  // Receive state machine
  urxb_pkg::urxb_state_e state_r;
  logic [3:0] samp_r;      // Sample number within the current bit
  logic [3:0] bit_r;       // Bits received after the start bit
  logic [1:0] votes_r;     // High samples seen among the first two centre ones
  logic [9:0] shift_r;     // Data plus parity, first bit in bit 0
  logic       prev_r;
  logic       in_window;
  logic       bit_end;
  logic       bit_val;
  assign in_window = (samp_r >= vote_a) && (samp_r <= vote_c);  // [RQ17] [RQ21]
  // Majority over the two earlier votes plus the current sample
  assign bit_val   = (votes_r + {1'h0, line_s}) >= 2'h2;         // [RQ21] [RQ18]
  assign bit_end   = (samp_r == vote_c);

  // Shifter hand-off to buffer
  logic             shf_valid_r;
  urxb_pkg::urxb_entry_s shf_r;
  logic             buf_ready;
  logic             ovr_pend_r;   // Overrun noted against next stored frame

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r <= 1'b1;
    end else if (sample_tick) begin
      prev_r <= line_s;
    end
  end

  // Sampling advances only on the tick; disable abandons at once
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= urxb_pkg::RX_IDLE;
      samp_r  <= 4'h0;
      bit_r   <= 4'h0;
      votes_r <= 2'h0;
      shift_r <= 10'h000;
    end else if (!rx_enable_bit) begin
      state_r <= urxb_pkg::RX_IDLE;  // [RQ14]
      samp_r  <= 4'h0;
      votes_r <= 2'h0;
    end else if (sample_tick) begin  // [RQ27]
      case (state_r)
        urxb_pkg::RX_IDLE: begin
          if (prev_r && !line_s) begin
            state_r <= urxb_pkg::RX_START;
            samp_r  <= 4'h2;  // This low sample is number 1
            votes_r <= 2'h0;
          end
        end
        urxb_pkg::RX_START: begin
          if (in_window) begin
            votes_r <= votes_r + {1'h0, line_s};
          end
          if (bit_end) begin
            if (bit_val) begin
              state_r <= urxb_pkg::RX_IDLE;  // [RQ18]
            end else begin
              state_r <= urxb_pkg::RX_BITS;  // [RQ19]
              bit_r   <= 4'h0;
            end
            votes_r <= 2'h0;
          end
          // Bit timing restarts from the accepted start bit
          samp_r <= (samp_r == last_state) ? 4'h0 : samp_r + 4'h1;  // [RQ20]
        end
        urxb_pkg::RX_BITS: begin
          samp_r <= (samp_r == last_state) ? 4'h0 : samp_r + 4'h1;  // [RQ20]
          if (in_window) begin
            votes_r <= votes_r + {1'h0, line_s};
          end
          if (bit_end) begin
            votes_r <= 2'h0;
            if (bit_r == frame_bits - 4'h1) begin
              // Stop bit decided; later stop bits fall into idle high
              state_r <= urxb_pkg::RX_IDLE;  // [RQ22]
            end else begin
              shift_r[bit_r] <= bit_val;
              bit_r          <= bit_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= urxb_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Completed frame assembly
  logic       stop_done;
  logic [8:0] data_mask;
  logic       par_calc;
  logic       par_bit;
  assign stop_done = rx_enable_bit && sample_tick && (state_r == urxb_pkg::RX_BITS)
                   && bit_end && (bit_r == frame_bits - 4'h1);
  assign data_mask = ~(9'h1FF << data_bits);                 // [RQ24]
  assign par_bit   = shift_r[data_bits];
  assign par_calc  = ^(shift_r[8:0] & data_mask);

  // Shift register holding stage; overrun tracked here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shf_valid_r <= 1'b0;
      shf_r       <= '0;
      ovr_pend_r  <= 1'b0;
    end else if (!rx_enable_bit) begin
      shf_valid_r <= 1'b0;  // [RQ4]
      ovr_pend_r  <= 1'b0;
    end else begin
      if (shf_valid_r && buf_ready) begin
        shf_valid_r <= 1'b0;
        ovr_pend_r  <= 1'b0;  // [RQ11]
      end
      // Full buffer, waiting frame and new accepted start: waiting frame is lost
      if (shf_valid_r && !buf_ready && state_r == urxb_pkg::RX_START && sample_tick
          && bit_end && !bit_val) begin
        ovr_pend_r <= 1'b1;  // [RQ10]
      end
      if (stop_done) begin
        shf_valid_r      <= 1'b1;
        shf_r.data       <= shift_r[8:0] & data_mask;  // [RQ24]
        shf_r.frame_err  <= ~bit_val;                   // [RQ23] [RQ9]
        shf_r.parity_err <= cfg.parity_enable_bit
                          & (par_calc ^ par_bit ^ cfg.parity_odd_sel);  // [RQ12] [RQ13]
        shf_r.overrun    <= ovr_pend_r | (shf_valid_r & !buf_ready);
      end
    end
  end

  // Two-entry buffer; depth bounds back-pressure to the holding stage
  urxb_pkg::urxb_entry_s mem_r [2];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] count_r;
  logic       do_wr;
  logic       do_rd;
  assign buf_ready = (count_r != urxb_pkg::BUF_DEPTH);
  assign do_wr     = rx_enable_bit && shf_valid_r && buf_ready;
  assign do_rd     = rx_enable_bit && data_read && (count_r != 2'h0);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else if (!rx_enable_bit) begin
      wr_ptr_r <= 1'b0;  // [RQ4]
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (do_rd) begin
        rd_ptr_r <= ~rd_ptr_r;  // [RQ2]
      end
      count_r <= count_r + {1'h0, do_wr} - {1'h0, do_rd};
    end
  end

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= shf_r;  // [RQ2]
    end
  end

  // Registered views of the next readable entry
  logic       cnt_nxt_nz;
  logic       rd_nxt;
  urxb_pkg::urxb_entry_s head;
  assign cnt_nxt_nz = (count_r + {1'h0, do_wr} - {1'h0, do_rd}) != 2'h0;
  assign rd_nxt     = do_rd ? ~rd_ptr_r : rd_ptr_r;
  // Entry just written may be the head when the buffer was empty
  assign head       = (do_wr && (count_r - {1'h0, do_rd}) == 2'h0) ? shf_r : mem_r[rd_nxt];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_data         <= urxb_pkg::DATA_RST[7:0];
      rx_ninth_bit    <= 1'b0;
      frame_err_flag  <= 1'b0;
      overrun_flag    <= 1'b0;
      parity_err_flag <= 1'b0;
      rx_complete     <= 1'b0;
      rx_irq          <= 1'b0;
      pin_override    <= 1'b0;
    end else begin
      rx_complete  <= rx_enable_bit && cnt_nxt_nz;  // [RQ3] [RQ4]
      rx_irq       <= rx_enable_bit && cnt_nxt_nz && rx_complete_irq_en
                   && global_irq_en;                 // [RQ5]
      pin_override <= rx_enable_bit;                 // [RQ25] [RQ14]
      if (rx_enable_bit && cnt_nxt_nz) begin
        rx_data         <= head.data[7:0];
        rx_ninth_bit    <= head.data[8];
        frame_err_flag  <= head.frame_err;           // [RQ9]
        overrun_flag    <= head.overrun;
        parity_err_flag <= head.parity_err;          // [RQ13]
      end else begin
        // Error flags only ever come from the buffer; no interrupt path
        frame_err_flag  <= 1'b0;                     // [RQ7]
        overrun_flag    <= 1'b0;
        parity_err_flag <= 1'b0;
      end
    end
  end

endmodule : urxb_receiver

//--- dv/urxb_receiver_properties.sv
// Checker: port-level properties of the serial receiver with two-entry buffer
`timescale 1ns/100ps

module urxb_receiver_properties (
  // Clock and reset
  input wire logic                clock,
  input wire logic                sys_rst,
  // Line, tick and controls
  input wire logic                serial_input_pin,
  input wire logic                sample_tick,
  input wire logic                rx_enable_bit,
  input wire logic                rx_complete_irq_en,
  input wire logic                global_irq_en,
  input wire urxb_pkg::urxb_cfg_s cfg,
  input wire logic                data_read,
  // Head entry and status
  input wire logic [7:0]          rx_data,
  input wire logic                rx_ninth_bit,
  input wire logic                frame_err_flag,
  input wire logic                overrun_flag,
  input wire logic                parity_err_flag,
  input wire logic                rx_complete,
  input wire logic                rx_irq,
  input wire logic                pin_override
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Two-cycle windows absorb the one-clock lag of the registered request
  empty_flags_a: assert property (
    !rx_complete |-> !(frame_err_flag || overrun_flag || parity_err_flag))
    else $error("status flags set while buffer empty");
  irq_set_a: assert property (
    (rx_complete && rx_complete_irq_en && global_irq_en && rx_enable_bit)[*2] |-> rx_irq)
    else $error("interrupt request missing");
  // Request is registered, so it answers to the enables of the previous cycle
  irq_gate_a: assert property (
    rx_irq |-> rx_complete && $past(rx_complete_irq_en) && $past(global_irq_en))
    else $error("interrupt request without cause");
  buffer_flush_a: assert property ((!rx_enable_bit)[*2] |-> !rx_complete && !rx_irq)
    else $error("buffer not flushed while disabled");
  own_pin_a: assert property (rx_enable_bit |=> pin_override)
    else $error("pin not taken over");
  release_pin_a: assert property ($fell(rx_enable_bit) |=> !pin_override)
    else $error("pin not released");
  head_hold_a: assert property (rx_complete && !data_read && rx_enable_bit |=>
    rx_complete && $stable({rx_ninth_bit, rx_data, frame_err_flag, overrun_flag, parity_err_flag}))
    else $error("head entry changed without read");
  short_zero_a: assert property (
    rx_complete && cfg.char_size_sel == 3'h0 |-> rx_data[7:5] == 3'h0)
    else $error("unused data bits not zero");
  ninth_zero_a: assert property (
    rx_complete && cfg.char_size_sel != urxb_pkg::CSZ_NINE |-> !rx_ninth_bit)
    else $error("ninth bit set for short character");
  parity_off_a: assert property (
    rx_complete && !cfg.parity_enable_bit |-> !parity_err_flag)
    else $error("parity error with checking off");
endmodule : urxb_receiver_properties

bind urxb_receiver urxb_receiver_properties u_props (.clock(clock), .sys_rst(sys_rst),
  .serial_input_pin(serial_input_pin), .sample_tick(sample_tick), .rx_enable_bit(rx_enable_bit),
  .rx_complete_irq_en(rx_complete_irq_en), .global_irq_en(global_irq_en), .cfg(cfg),
  .data_read(data_read), .rx_data(rx_data), .rx_ninth_bit(rx_ninth_bit),
  .frame_err_flag(frame_err_flag), .overrun_flag(overrun_flag), .parity_err_flag(parity_err_flag),
  .rx_complete(rx_complete), .rx_irq(rx_irq), .pin_override(pin_override));

//--- dv/urxb_line_tx.sv
// Partner: remote serial transmitter driving the receive line
`timescale 1ns/100ps

module urxb_line_tx (
  // Clock and oversample tick
  input  wire logic clock,
  input  wire logic sample_tick,
  // Serial line, idle high
  output logic      line
);
  initial line = 1'b1;

  // Hold one level for a count of ticks; bit length follows the receiver's rate
  task automatic hold(input logic v, input int ticks);
    line <= v;
    repeat (ticks) @(posedge clock iff sample_tick);
  endtask : hold

  // Frame is start, data LSB first, optional parity, stop, then one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic po,
                      input logic bad, input logic stop, input int spb);
    logic p;
    p = ^(d & ((9'h1 << nb) - 9'h1)) ^ po ^ bad;
    // Launch every frame on a rising edge, like the other inputs
    @(posedge clock);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) hold(d[i], spb);
    if (pe) hold(p, spb);
    hold(stop, spb);
    hold(1'b1, spb);
  endtask : send
endmodule : urxb_line_tx

//--- dv/tb.sv
// Testbench: frame-level tests of the serial receiver with two-entry buffer
`timescale 1ns/100ps

module tb;
  logic                clock, sys_rst, sample_tick, rx_enable_bit, data_read;
  logic                rx_complete_irq_en, global_irq_en;
  urxb_pkg::urxb_cfg_s cfg;
  logic [7:0]          rx_data;
  logic                rx_ninth_bit, frame_err_flag, overrun_flag, parity_err_flag;
  logic                rx_complete, rx_irq, pin_override;
  wire                 serial_line;
  int                  error_cnt, checked;

  urxb_receiver dut (.clock(clock), .sys_rst(sys_rst), .serial_input_pin(serial_line),
    .sample_tick(sample_tick), .rx_enable_bit(rx_enable_bit),
    .rx_complete_irq_en(rx_complete_irq_en),
    .global_irq_en(global_irq_en), .cfg(cfg), .data_read(data_read), .rx_data(rx_data),
    .rx_ninth_bit(rx_ninth_bit), .frame_err_flag(frame_err_flag), .overrun_flag(overrun_flag),
    .parity_err_flag(parity_err_flag), .rx_complete(rx_complete), .rx_irq(rx_irq),
    .pin_override(pin_override));
  urxb_line_tx u_tx (.clock(clock), .sample_tick(sample_tick), .line(serial_line));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Tick on every second clock keeps frames short
  always @(posedge clock) sample_tick <= ~sample_tick;

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Wait for a buffered character, sampling away from the rising edge
  task automatic waitc;
    for (int n = 0; n < 3000 && rx_complete !== 1'b1; n++) @(negedge clock);
    chk("rx_complete", 9'h001, {8'h00, rx_complete});
  endtask : waitc

  // Status and ninth bit are taken before the data location is read
  task automatic rd(input logic [8:0] d, input logic [2:0] f);
    waitc();
    chk("data", d, {rx_ninth_bit, rx_data});
    chk("flags", {6'h00, f}, {6'h00, frame_err_flag, overrun_flag, parity_err_flag});
    @(posedge clock) data_read <= 1'b1;
    @(posedge clock) data_read <= 1'b0;
    @(negedge clock);
  endtask : rd

  task automatic setc(input logic [5:0] c);
    @(posedge clock) cfg <= c;
  endtask : setc

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog sized well above the frame traffic below
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {sys_rst, sample_tick, rx_enable_bit, data_read} = 4'h8;
    {rx_complete_irq_en, global_irq_en, error_cnt, checked} = '0;
    cfg = 6'h18;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rx_enable_bit <= 1'b1;
    u_tx.send(9'h0A5, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    rd(9'h0A5, 3'h0);
    chk("empty", 9'h000, {8'h00, rx_complete});
    $display("test plain done");
    setc(6'h3C);
    u_tx.send(9'h1C3, 9, 1'b1, 1'b0, 1'b1, 1'b0, 16);
    u_tx.send(9'h0C3, 9, 1'b1, 1'b0, 1'b0, 1'b1, 16);
    rd(9'h1C3, 3'b101);
    rd(9'h0C3, 3'b000);
    $display("test ninth done");
    setc(6'h07);
    u_tx.send(9'h1F5, 5, 1'b1, 1'b1, 1'b0, 1'b1, 8);
    u_tx.send(9'h00A, 5, 1'b1, 1'b1, 1'b1, 1'b1, 8);
    rd(9'h015, 3'b000);
    rd(9'h00A, 3'b001);
    $display("test double done");
    setc(6'h18);
    u_tx.hold(1'b0, 6);
    u_tx.hold(1'b1, 200);  // Longer than a frame, so a wrongly accepted start would land
    chk("noise", 9'h000, {8'h00, rx_complete});
    u_tx.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    rd(9'h03C, 3'b000);
    $display("test noise done");
    u_tx.send(9'h011, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    u_tx.send(9'h022, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    u_tx.send(9'h033, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    u_tx.send(9'h044, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    rd(9'h011, 3'b000);
    rd(9'h022, 3'b000);
    rd(9'h044, 3'b010);
    u_tx.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    rd(9'h055, 3'b000);
    $display("test overrun done");
    @(posedge clock) {rx_complete_irq_en, global_irq_en} <= 2'h3;
    u_tx.send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    waitc();
    repeat (2) @(negedge clock);
    chk("rx_irq", 9'h001, {8'h00, rx_irq});
    @(posedge clock) global_irq_en <= 1'b0;
    repeat (2) @(negedge clock);
    chk("rx_irq", 9'h000, {8'h00, rx_irq});
    @(posedge clock) global_irq_en <= 1'b1;
    // Service routine reads the data, which must drop the request
    rd(9'h066, 3'b000);
    chk("rx_irq", 9'h000, {8'h00, rx_irq});
    $display("test irq done");
    // Software drain: read the data location until receive-complete clears
    u_tx.send(9'h088, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    u_tx.send(9'h099, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    for (int n = 0; n < 4 && rx_complete === 1'b1; n++) begin
      @(posedge clock) data_read <= 1'b1;
      @(posedge clock) data_read <= 1'b0;
      @(negedge clock);
    end
    chk("drain", 9'h000, {8'h00, rx_complete});
    $display("test drain done");
    // Disable with a character still buffered; it must be discarded
    u_tx.send(9'h0AA, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    waitc();
    @(posedge clock) rx_enable_bit <= 1'b0;
    repeat (2) @(negedge clock);
    chk("flush", 9'h000, {8'h00, rx_complete});
    chk("rx_irq", 9'h000, {8'h00, rx_irq});
    chk("pin_override", 9'h000, {8'h00, pin_override});
    @(posedge clock) rx_enable_bit <= 1'b1;
    u_tx.send(9'h077, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
    chk("pin_override", 9'h001, {8'h00, pin_override});
    rd(9'h077, 3'b000);
    $display("test flush done");
    tally_and_finish();
  end
endmodule : tb
